// >>> pkg/cmb_defs.vh
`ifndef CMB_DEFS_VH
`define CMB_DEFS_VH

// clock and wakeup glitch filter timing
`define CMB_CLK_NS 100
`define CMB_WUF_NS 2000
`define CMB_WUF_CYC ((`CMB_WUF_NS + `CMB_CLK_NS - 1) / `CMB_CLK_NS)
`define CMB_WUF_W 5

// field widths
`define CMB_PRE_W 6
`define CMB_TS1_W 4
`define CMB_TS2_W 3
`define CMB_SJW_W 2
`define CMB_CNT_W 5

// field limits, stored as length minus one
`define CMB_TS1_MIN 4'h3
`define CMB_TS2_MIN 3'h1

// reset values of the timing fields
`define CMB_PRE_RST 6'h00
`define CMB_TS1_RST 4'h3
`define CMB_TS2_RST 3'h1
`define CMB_SJW_RST 2'h0

// recessive bits needed to rejoin the bus
`define CMB_IDLE_BITS 4'hB

// bit segment states
`define CMB_ST_SYNC 2'h0
`define CMB_ST_SEG1 2'h1
`define CMB_ST_SEG2 2'h2

`endif

// >>> tb/cmb_bus_node.sv
`timescale 1ns/1ns
module cmb_bus_node (
	// clock
	input wire clk,
	// bus seen from the far node
	input wire canTx,
	output wire canRx
);
	reg drive = 1'b1;
	// wired-and bus, dominant wins
	assign canRx = canTx & drive;
	task dom(input integer k);
		begin
			@(negedge clk) drive = 1'b0;
			repeat (k) @(negedge clk);
			drive = 1'b1;
		end
	endtask
endmodule

// >>> tb/cmb_mode_checker.sv
`timescale 1ns/1ns
module cmb_mode_checker (
	// clock and reset
	input wire clk, input wire sys_rst,
	// mode inputs
	input wire cpuStop, input wire cpuWait, input wire softResetBit, input wire sleepRequest,
	input wire intRequest, input wire timerLinkEnable, input wire frameActive, input wire txBit,
	// outputs
	input wire canTx, input wire sleepAck, input wire powerDown, input wire regAccessOk,
	input wire protoHalt, input wire abortPulse, input wire rxEnable, input wire waitWake,
	input wire bitStart, input wire timerLinkOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	pd_entry_a: assert property (cpuStop |=> powerDown && !regAccessOk && protoHalt)
		else $error("power down not entered");
	pd_recessive_a: assert property (powerDown |-> canTx)
		else $error("transmit not recessive");
	soft_halt_a: assert property (softResetBit |=> protoHalt)
		else $error("soft reset did not halt");
	abort_now_a: assert property ($rose(softResetBit || cpuStop) && frameActive |=> abortPulse)
		else $error("frame not aborted");
	sleep_ack_a: assert property (sleepRequest && !frameActive && !softResetBit && !cpuStop && !sleepAck |=> sleepAck)
		else $error("sleep not acknowledged");
	wait_wake_a: assert property (cpuWait && intRequest |=> waitWake)
		else $error("wait not ended");
	link_gate_a: assert property (!timerLinkEnable |=> !timerLinkOut)
		else $error("link out while disabled");
	tx_point_a: assert property (bitStart && !$past(protoHalt) && !protoHalt |-> canTx == $past(txBit))
		else $error("transmit bit wrong");
	rx_halt_a: assert property (protoHalt |=> !rxEnable)
		else $error("receive enabled while halted");
endmodule
bind cmb_mode_timing cmb_mode_checker chk (.*);

// >>> tb/cmb_mode_timing_tb.sv
`timescale 1ns/1ns
module cmb_mode_timing_tb;
	reg clk = 0, sys_rst = 1, cpuStop = 0, cpuWait = 0, softResetBit = 0, sleepRequest = 0;
	reg wakeupFilterMode = 0, timerLinkEnable = 0, intRequest = 0, cfgWrite = 0;
	reg cfgClockSourceSelect = 0, cfgThreeSamples = 0, xtalTick = 0, pllTick = 1;
	reg frameActive = 0, frameValid = 0, txBit = 1;
	reg [5:0] cfgPrescale = 6'h00;
	reg [3:0] cfgTimeSegOne = 4'h3;
	reg [2:0] cfgTimeSegTwo = 3'h1;
	reg [1:0] cfgJumpWidth = 2'h0;
	wire canRx, canTx, sleepAck, powerDown, regAccessOk, protoHalt, abortPulse, rxEnable, busWake;
	wire waitWake, tqTick, bitStart, samplePoint, sampledBit, timerLinkOut;
	integer err_total = 0, n_compared = 0, seed = 32'hfcfa64e0, i, n, ex, wakes = 0, tqs = 0, sp = 0;
	cmb_mode_timing dut (.*);
	cmb_bus_node peer (.clk(clk), .canTx(canTx), .canRx(canRx));
	always #50 clk = ~clk;
	always @(negedge clk) xtalTick <= ~xtalTick;
	always @(negedge clk) if (busWake === 1'b1) wakes = wakes + 1;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge clk);
	endtask
	task fin(input integer k);
		$display("test %0d done", k);
	endtask
	task cfg(input s, input [5:0] p, input [3:0] a, input [2:0] b);
		begin
			cfgClockSourceSelect = s; cfgPrescale = p; cfgTimeSegOne = a; cfgTimeSegTwo = b;
			cfgWrite = 1; cyc(1); cfgWrite = 0; cyc(1);
		end
	endtask
	// model: sync + both segments, short fields forced up
	function integer bitTq(input [3:0] a, input [2:0] b);
		bitTq = 3 + (a < 3 ? 3 : a) + (b == 0 ? 1 : b);
	endfunction
	function integer bitCyc(input s, input [5:0] p, input [3:0] a, input [2:0] b);
		bitCyc = (p + 1) * (s ? 1 : 2) * bitTq(a, b);
	endfunction
	task period(output integer c);
		begin
			c = 0;
			while (bitStart !== 1'b1 && c < 3000) begin cyc(1); c = c + 1; end
			c = 0;
			tqs = 0;
			cyc(1);
			if (tqTick === 1'b1) tqs = tqs + 1;
			while (bitStart !== 1'b1 && c < 3000) begin
				cyc(1);
				c = c + 1;
				if (tqTick === 1'b1) tqs = tqs + 1;
			end
			c = c + 1;
		end
	endtask
	// far node pulls the bus low on quanta j to j+w-1 of the next bit, one quantum per cycle
	task edgeBit(input integer j, input integer w, output integer c);
		begin
			c = 0;
			while (bitStart !== 1'b1 && c < 3000) begin cyc(1); c = c + 1; end
			cyc(j - 2);
			peer.dom(w);
			sp = samplePoint;
			c = j + w - 1;
			while (bitStart !== 1'b1 && c < 3000) begin cyc(1); c = c + 1; end
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		#6000000;
		err_total = err_total + 1;
		end_of_test;
	end
	initial begin
		cyc(10); sys_rst = 0; cyc(1);
		chk(canTx, 1); chk(sleepAck, 0); chk(regAccessOk, 1); chk(rxEnable, 0);
		fin(1);
		for (i = 0; i < 6; i = i + 1) begin
			softResetBit = 1; cyc(2);
			if (i == 0) cfg(0, 6'h00, 4'h0, 3'h0);
			else if (i == 1) cfg(1, 6'h02, 4'hF, 3'h7);
			else if (i == 2) cfg(1, 6'h00, 4'h5, 3'h2);
			else cfg($random(seed), $random(seed) & 6'h03, $random(seed), $random(seed));
			ex = bitCyc(cfgClockSourceSelect, cfgPrescale, cfgTimeSegOne, cfgTimeSegTwo);
			softResetBit = 0; cyc(1);
			chk(rxEnable, 0);
			period(n); period(n);
			chk(n, ex);
			chk(tqs, bitTq(cfgTimeSegOne, cfgTimeSegTwo));
			cfg(1, 6'h05, 4'h9, 3'h6);
			period(n); period(n);
			chk(n, ex);
		end
		repeat (13) period(n);
		chk(rxEnable, 1);
		fin(2);
		for (i = 0; i < 8; i = i + 1) begin
			txBit = $random(seed); period(n);
			chk(canTx, txBit);
		end
		txBit = 1; period(n); period(n);
		fin(3);
		timerLinkEnable = 1; frameValid = 1; cyc(1); frameValid = 0;
		n = 0;
		while (timerLinkOut !== 1'b1 && n < 3000) begin cyc(1); n = n + 1; end
		n = 0;
		while (timerLinkOut === 1'b1 && n < 3000) begin cyc(1); n = n + 1; end
		chk(n, ex);
		timerLinkEnable = 0; frameValid = 1; cyc(1); frameValid = 0;
		for (i = 0; i < 3 * ex; i = i + 1) begin cyc(1); if (timerLinkOut !== 1'b0) n = 0; end
		chk(n, ex);
		fin(4);
		frameActive = 1; cyc(3); softResetBit = 1; cyc(1);
		chk(abortPulse, 1);
		cyc(1); chk(protoHalt, 1); chk(canTx, 1);
		softResetBit = 0; txBit = 0; cyc(3 * ex); cpuStop = 1; cyc(1);
		chk(abortPulse, 1); chk(powerDown, 1); chk(regAccessOk, 0);
		cyc(1); chk(canTx, 1);
		frameActive = 0; txBit = 1; wakeupFilterMode = 1; cyc(3); wakes = 0;
		peer.dom(5); cyc(5); chk(wakes, 0);
		peer.dom(25); cyc(5); chk(wakes, 1);
		wakeupFilterMode = 0; peer.dom(1); cyc(5); chk(wakes, 2);
		cpuStop = 0; cyc(2);
		fin(5);
		cpuWait = 1; intRequest = 1; cyc(2); chk(waitWake, 1);
		intRequest = 0; cyc(2); chk(waitWake, 0); cpuWait = 0;
		sleepRequest = 1; cyc(2); chk(sleepAck, 1); chk(canTx, 1);
		softResetBit = 1; cyc(1); chk(abortPulse, 0); chk(sleepAck, 0);
		softResetBit = 0; cyc(2); chk(sleepAck, 1);
		cpuStop = 1; cyc(1); chk(abortPulse, 0); chk(powerDown, 1);
		cpuStop = 0; cyc(2); chk(sleepAck, 1);
		sleepRequest = 0; cyc(2); chk(sleepAck, 0);
		fin(6);
		frameActive = 1;
		cfgJumpWidth = 2'h1;
		for (i = 0; i < 2; i = i + 1) begin
			softResetBit = 1; cyc(2); cfgThreeSamples = (i == 1);
			cfg(1, 6'h00, 4'h7, 3'h3); softResetBit = 0;
			// glitch on the sample quantum only: one sample sees it, three outvote it
			edgeBit(9, 1, n);
			chk(sp, 1);
			chk(sampledBit, i);
			chk(n, bitTq(4'h7, 3'h3));
		end
		// late edge, phase error 3, lengthened by the jump width 2
		edgeBit(4, 1, n); chk(n, bitTq(4'h7, 3'h3) + 2);
		// early edge four quanta ahead, shortened by the jump width 2
		edgeBit(10, 1, n); chk(n, bitTq(4'h7, 3'h3) - 2);
		fin(7);
		end_of_test;
	end
endmodule

// >>> verilog/cmb_mode_timing.v
`timescale 1ns/1ns
`include "cmb_defs.vh"

module cmb_mode_timing (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// processor mode and control bits
	input wire cpuStop,
	input wire cpuWait,
	input wire softResetBit,
	input wire sleepRequest,
	input wire wakeupFilterMode,
	input wire timerLinkEnable,
	input wire intRequest,
	// bus timing configuration
	input wire cfgWrite,
	input wire cfgClockSourceSelect,
	input wire cfgThreeSamples,
	input wire [`CMB_PRE_W-1:0] cfgPrescale,
	input wire [`CMB_TS1_W-1:0] cfgTimeSegOne,
	input wire [`CMB_TS2_W-1:0] cfgTimeSegTwo,
	input wire [`CMB_SJW_W-1:0] cfgJumpWidth,
	// protocol clock sources as enable pulses
	input wire xtalTick,
	input wire pllTick,
	// protocol engine
	input wire frameActive,
	input wire frameValid,
	input wire txBit,
	// bus pins
	input wire canRx,
	output reg canTx,
	// mode status
	output reg sleepAck,
	output reg powerDown,
	output reg regAccessOk,
	output reg protoHalt,
	output reg abortPulse,
	output reg rxEnable,
	output reg busWake,
	output reg waitWake,
	// bit timing status
	output reg tqTick,
	output reg bitStart,
	output reg samplePoint,
	output reg sampledBit,
	// capture timer channel 0 input
	output reg timerLinkOut
);

	reg clkSel_r;
	reg threeSamp_r;
	reg [`CMB_PRE_W-1:0] pre_r;
	reg [`CMB_TS1_W-1:0] ts1_r;
	reg [`CMB_TS2_W-1:0] ts2_r;
	reg [`CMB_SJW_W-1:0] sjw_r;
	reg [`CMB_PRE_W-1:0] preCnt_r;
	reg [1:0] state_r;
	reg [`CMB_CNT_W-1:0] cnt_r;
	reg [`CMB_CNT_W-1:0] seg1End_r;
	reg [`CMB_CNT_W-1:0] seg2End_r;
	reg resynced_r;
	reg rxPrev_r;
	reg [1:0] samp_r;
	reg haltPrev_r;
	reg [3:0] idleCnt_r;
	reg tlPend_r;
	reg tlAct_r;
	wire srcTick;
	wire haltNow;
	wire tqNow;
	wire fallEdge;
	wire wakeFromFilter;
	wire [`CMB_CNT_W-1:0] sjwLen;
	wire [`CMB_CNT_W-1:0] phaseErr;
	wire [`CMB_CNT_W-1:0] seg2Left;
	wire sampleBitNow;

	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	assign srcTick = clkSel_r ? pllTick : xtalTick;
	assign haltNow = softResetBit | cpuStop | sleepAck;
	assign tqNow = srcTick && (preCnt_r == pre_r) && !haltNow;
	assign fallEdge = rxPrev_r && !canRx;
	assign sjwLen = {3'h0, sjw_r} + 5'h01;
	assign phaseErr = cnt_r + 5'h01;
	assign seg2Left = seg2End_r - cnt_r;
	assign sampleBitNow = threeSamp_r ? maj3(samp_r[1], samp_r[0], canRx) : canRx;

	cmb_wake_filter u_wake (
		.clk(clk),
		.sys_rst(sys_rst),
		.armed(sleepAck | cpuStop),
		.filterOn(wakeupFilterMode),
		.canRx(canRx),
		.wakePulse(wakeFromFilter)
	);

	// timing configuration, locked unless soft reset and powered
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clkSel_r <= 1'b0;
			threeSamp_r <= 1'b0;
			pre_r <= `CMB_PRE_RST;
			ts1_r <= `CMB_TS1_RST;
			ts2_r <= `CMB_TS2_RST;
			sjw_r <= `CMB_SJW_RST;
		end else if (cfgWrite && softResetBit && !cpuStop) begin
			clkSel_r <= cfgClockSourceSelect;
			threeSamp_r <= cfgThreeSamples;
			pre_r <= cfgPrescale;
			// out-of-range lengths are raised to the minimum
			ts1_r <= (cfgTimeSegOne < `CMB_TS1_MIN) ? `CMB_TS1_MIN : cfgTimeSegOne;
			ts2_r <= (cfgTimeSegTwo < `CMB_TS2_MIN) ? `CMB_TS2_MIN : cfgTimeSegTwo;
			sjw_r <= cfgJumpWidth;
		end
	end

	// operating modes and handshakes
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sleepAck <= 1'b0;
			powerDown <= 1'b0;
			regAccessOk <= 1'b1;
			protoHalt <= 1'b0;
			abortPulse <= 1'b0;
			busWake <= 1'b0;
			waitWake <= 1'b0;
			haltPrev_r <= 1'b0;
		end else begin
			powerDown <= cpuStop;
			regAccessOk <= !cpuStop;
			protoHalt <= haltNow;
			haltPrev_r <= softResetBit | cpuStop;
			// stop cuts any frame at once, no frame boundary wait
			abortPulse <= (softResetBit | cpuStop) && !haltPrev_r && frameActive;
			busWake <= wakeFromFilter && cpuStop;
			waitWake <= cpuWait && intRequest;
			if (!sleepRequest || softResetBit || wakeFromFilter)
				sleepAck <= 1'b0;
			else if (!frameActive && !cpuStop)
				sleepAck <= 1'b1;
		end
	end

	// time quantum prescaler
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			preCnt_r <= 6'h00;
			tqTick <= 1'b0;
		end else begin
			tqTick <= tqNow;
			if (haltNow)
				preCnt_r <= 6'h00;
			else if (srcTick)
				preCnt_r <= (preCnt_r == pre_r) ? 6'h00 : preCnt_r + 6'h01;
		end
	end

	// bit segmentation and resynchronisation
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= `CMB_ST_SYNC;
			cnt_r <= 5'h00;
			seg1End_r <= 5'h03;
			seg2End_r <= 5'h01;
			resynced_r <= 1'b0;
			rxPrev_r <= 1'b1;
			samp_r <= 2'h3;
			canTx <= 1'b1;
			bitStart <= 1'b0;
			samplePoint <= 1'b0;
			sampledBit <= 1'b1;
		end else begin
			bitStart <= 1'b0;
			samplePoint <= 1'b0;
			if (haltNow) begin
				state_r <= `CMB_ST_SYNC;
				cnt_r <= 5'h00;
				rxPrev_r <= 1'b1;
				canTx <= 1'b1;
			end else if (tqNow) begin
				rxPrev_r <= canRx;
				samp_r <= {samp_r[0], canRx};
				case (state_r)
					`CMB_ST_SYNC: begin
						state_r <= `CMB_ST_SEG1;
						cnt_r <= 5'h00;
						seg1End_r <= {1'b0, ts1_r};
						seg2End_r <= {2'h0, ts2_r};
						resynced_r <= 1'b0;
					end
					`CMB_ST_SEG1: begin
						if (fallEdge && !frameActive) begin
							// hard sync on idle bus
							cnt_r <= 5'h00;
							seg1End_r <= {1'b0, ts1_r};
							resynced_r <= 1'b1;
						end else if (fallEdge && !resynced_r && cnt_r != seg1End_r) begin
							// late edge lengthens segment one
							seg1End_r <= seg1End_r + ((phaseErr < sjwLen) ? phaseErr : sjwLen);
							resynced_r <= 1'b1;
							cnt_r <= cnt_r + 5'h01;
						end else if (cnt_r == seg1End_r) begin
							samplePoint <= 1'b1;
							sampledBit <= sampleBitNow;
							state_r <= `CMB_ST_SEG2;
							cnt_r <= 5'h00;
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					`CMB_ST_SEG2: begin
						if (fallEdge && !resynced_r && seg2Left < sjwLen) begin
							// early edge: this quantum serves as sync
							state_r <= `CMB_ST_SEG1;
							cnt_r <= 5'h00;
							seg1End_r <= {1'b0, ts1_r};
							seg2End_r <= {2'h0, ts2_r};
							resynced_r <= 1'b0;
							bitStart <= 1'b1;
							canTx <= txBit;
						end else if (fallEdge && !resynced_r && seg2Left == sjwLen) begin
							// shortened by the full jump width: segment two ends here
							state_r <= `CMB_ST_SYNC;
							cnt_r <= 5'h00;
							bitStart <= 1'b1;
							canTx <= txBit;
						end else if (fallEdge && !resynced_r) begin
							seg2End_r <= seg2End_r - sjwLen;
							resynced_r <= 1'b1;
							cnt_r <= cnt_r + 5'h01;
						end else if (cnt_r >= seg2End_r) begin
							// bit time is sync plus both segments
							state_r <= `CMB_ST_SYNC;
							cnt_r <= 5'h00;
							bitStart <= 1'b1;
							canTx <= txBit;
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					default: begin
						state_r <= `CMB_ST_SYNC;
						cnt_r <= 5'h00;
					end
				endcase
			end
		end
	end

	// bus rejoin after wake or halt: eleven recessive samples
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			idleCnt_r <= 4'h0;
			rxEnable <= 1'b0;
		end else if (haltNow) begin
			idleCnt_r <= 4'h0;
			rxEnable <= 1'b0;
		end else if (samplePoint && !rxEnable) begin
			if (!sampledBit)
				idleCnt_r <= 4'h0;
			else if (idleCnt_r == `CMB_IDLE_BITS - 4'h1)
				rxEnable <= 1'b1;
			else
				idleCnt_r <= idleCnt_r + 4'h1;
		end
	end

	// timer link: one bit time, starting at the next bit boundary
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tlPend_r <= 1'b0;
			tlAct_r <= 1'b0;
			timerLinkOut <= 1'b0;
		end else begin
			if (haltNow) begin
				tlPend_r <= 1'b0;
				tlAct_r <= 1'b0;
			end else begin
				if (frameValid)
					tlPend_r <= 1'b1;
				else if (bitStart && tlPend_r)
					tlPend_r <= 1'b0;
				if (bitStart)
					tlAct_r <= tlPend_r && !frameValid;
			end
			timerLinkOut <= tlAct_r && timerLinkEnable;
		end
	end

endmodule

// >>> verilog/cmb_wake_filter.v
`timescale 1ns/1ns
`include "cmb_defs.vh"

module cmb_wake_filter (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// control
	input wire armed,
	input wire filterOn,
	// bus input
	input wire canRx,
	// result
	output reg wakePulse
);

	reg [`CMB_WUF_W-1:0] lowCnt_r;
	reg fired_r;
	wire dominantLongEnough;

	assign dominantLongEnough = (lowCnt_r >= `CMB_WUF_CYC - 1);

	// count consecutive dominant cycles, fire once per low phase
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lowCnt_r <= 5'h00;
			fired_r <= 1'b0;
			wakePulse <= 1'b0;
		end else begin
			wakePulse <= 1'b0;
			if (!armed || canRx) begin
				lowCnt_r <= 5'h00;
				fired_r <= 1'b0;
			end else begin
				if (!dominantLongEnough)
					lowCnt_r <= lowCnt_r + 5'h01;
				// short glitches are swallowed when the filter is on
				if (!fired_r && (!filterOn || dominantLongEnough)) begin
					wakePulse <= 1'b1;
					fired_r <= 1'b1;
				end
			end
		end
	end

endmodule
